/* File: sbit_pkg.sv */
/*
 * Package of the sixteen-bit interval timer: register byte offsets, control
 * field positions, reset values and prescaler terminal counts.
 * Assumes a 32-bit APB slave with each register in one aligned word.
 */
package sbit_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_COUNT = 12'h004;
    localparam logic [11:0] OFS_PERIOD = 12'h008;
    localparam logic [11:0] OFS_STATUS = 12'h00c;
    localparam logic [11:0] OFS_MASK = 12'h010;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    localparam int BIT_COUNT_RUN = 15;
    localparam int BIT_HALT_IN_IDLE = 13;
    localparam int BIT_GATE_ACCUMULATE_EN = 6;
    localparam int BIT_PRESCALE_HI = 5;
    localparam int BIT_PRESCALE_LO = 4;
    localparam int BIT_EXT_INPUT_SYNC = 2;
    localparam int BIT_COUNT_SOURCE_SEL = 1;
    localparam logic [15:0] CONTROL_WRITABLE = 16'ha076;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic STATUS_RESET = 1'b0;
    localparam logic MASK_RESET = 1'b0;

    // ------------------------------------------------------------------
    // Prescaler terminal counts for 1:1, 1:8, 1:64 and 1:256
    // ------------------------------------------------------------------
    localparam logic [1:0] PRESCALE_1 = 2'h0;
    localparam logic [1:0] PRESCALE_8 = 2'h1;
    localparam logic [1:0] PRESCALE_64 = 2'h2;
    localparam logic [7:0] TERM_1 = 8'h00;
    localparam logic [7:0] TERM_8 = 8'h07;
    localparam logic [7:0] TERM_64 = 8'h3f;
    localparam logic [7:0] TERM_256 = 8'hff;

endpackage : sbit_pkg

/* File: sbit_sync3.sv */
/*
 * Three-stage synchroniser for one pin level, with a filtered level and a
 * one-cycle rising-edge pulse.
 * Assumes the pin is asynchronous to core_clk and rst_n is already synchronous.
 */
`timescale 1ns/10ps

module sbit_sync3 (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pin_in,
    output logic level,
    output logic rise
);

    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // A change is believed only once the second and third stages agree.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end

    assign level = level_q;
    assign rise = (s2_q == s3_q) && s3_q && !level_q;

endmodule : sbit_sync3

/* File: sbit_timer.sv */
/*
 * Sixteen-bit interval timer / event counter with APB register access,
 * prescaler, gate, idle halt, period match and a masked interrupt.
 * Assumes core_clk is the instruction-cycle clock and idle_mode comes from
 * logic on the same clock; ext_count_pin and gate_in are asynchronous pins.
 */
`timescale 1ns/10ps

// Contract
// RL1: Sixteen-bit free-running timer or event counter.
// RL2: Timer modes count the instruction-cycle clock.
// RL3: Counter modes count the external pin.
// RL4: External synchronisation follows the prescaler.
// RL5: Asynchronous counter mode skips synchronisation.
// RL6: Run bit starts and stops counting.
// RL7: Idle-stop bit halts counting in idle.
// RL8: Gate bit enables gated accumulation internally.
// RL9: Gate bit ignored with external source.
// RL10: Prescale field divides by 1, 8, 64, 256.
// RL11: Source bit picks pin edges or clock.
// RL12: Sync bit chooses synchronised external counting.
// RL13: Count writes ignored in running synchronous counter.
// RL14: Period match clears count, sets flag.
// RL15: Gated mode counts only while gate high.
module sbit_timer (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_count_pin,
    input wire logic gate_in,
    input wire logic idle_mode,
    output logic irq
);

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic rst_a_q;
    logic rst_n;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_a_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_n <= rst_a_q;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] timer_control_q;
    logic [15:0] count_value_q;
    logic [15:0] period_q;
    logic status_q;
    logic mask_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    logic count_run;
    logic halt_in_idle;
    logic gate_accumulate_en;
    logic [1:0] prescale_sel;
    logic ext_input_sync;
    logic count_source_sel;

    assign count_run = timer_control_q[sbit_pkg::BIT_COUNT_RUN];
    assign halt_in_idle = timer_control_q[sbit_pkg::BIT_HALT_IN_IDLE];
    assign gate_accumulate_en = timer_control_q[sbit_pkg::BIT_GATE_ACCUMULATE_EN];
    assign prescale_sel = timer_control_q[sbit_pkg::BIT_PRESCALE_HI:sbit_pkg::BIT_PRESCALE_LO];
    assign ext_input_sync = timer_control_q[sbit_pkg::BIT_EXT_INPUT_SYNC];
    assign count_source_sel = timer_control_q[sbit_pkg::BIT_COUNT_SOURCE_SEL];

    logic setup_phase;
    logic wr_en;
    logic ctrl_wr;
    logic cnt_wr;
    logic per_wr;
    logic stat_wr;
    logic mask_wr;
    logic sync_counter;

    assign setup_phase = psel && !penable;
    assign wr_en = psel && penable && pwrite;
    assign ctrl_wr = wr_en && (paddr == sbit_pkg::OFS_CONTROL);
    assign cnt_wr = wr_en && (paddr == sbit_pkg::OFS_COUNT);
    assign per_wr = wr_en && (paddr == sbit_pkg::OFS_PERIOD);
    assign stat_wr = wr_en && (paddr == sbit_pkg::OFS_STATUS);
    assign mask_wr = wr_en && (paddr == sbit_pkg::OFS_MASK);
    assign sync_counter = count_run && count_source_sel && ext_input_sync;

    // Zero wait states: the answer is prepared in the setup cycle.
    assign pready = psel && penable;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_control_q <= sbit_pkg::CONTROL_RESET;
        end else if (ctrl_wr) begin
            timer_control_q <= pwdata[15:0] & sbit_pkg::CONTROL_WRITABLE;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            period_q <= sbit_pkg::PERIOD_RESET;
            mask_q <= sbit_pkg::MASK_RESET;
        end else begin
            if (per_wr) begin
                period_q <= pwdata[15:0];
            end
            if (mask_wr) begin
                mask_q <= pwdata[0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            pslverr_q <= 1'b0;
            if (paddr == sbit_pkg::OFS_CONTROL) begin
                prdata_q <= {16'h0000, timer_control_q};
            end else if (paddr == sbit_pkg::OFS_COUNT) begin
                prdata_q <= {16'h0000, count_value_q};
            end else if (paddr == sbit_pkg::OFS_PERIOD) begin
                prdata_q <= {16'h0000, period_q};
            end else if (paddr == sbit_pkg::OFS_STATUS) begin
                prdata_q <= {31'h0000_0000, status_q};
            end else if (paddr == sbit_pkg::OFS_MASK) begin
                prdata_q <= {31'h0000_0000, mask_q};
            end else begin
                prdata_q <= 32'h0000_0000;
                pslverr_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Count source, gate and prescaler
    // ------------------------------------------------------------------
    logic ext_rise;
    logic gate_level;
    logic active;
    logic gate_ok;
    logic src_tick;
    logic pre_in;
    logic pre_out;
    logic cnt_tick;
    logic [7:0] pre_cnt_q;
    logic [7:0] pre_term;
    logic [1:0] resync_q;

    sbit_sync3 u_ext_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(ext_count_pin),
        .level(),
        .rise(ext_rise)
    );

    sbit_sync3 u_gate_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(gate_in),
        .level(gate_level),
        .rise()
    );

    assign active = count_run && !(halt_in_idle && idle_mode); // RL6 RL7
    assign src_tick = count_source_sel ? ext_rise : 1'b1; // RL2 RL3 RL11
    // The gate only qualifies the internal clock; an external source ignores it.
    assign gate_ok = count_source_sel || !gate_accumulate_en || gate_level; // RL8 RL9 RL15
    assign pre_in = active && src_tick && gate_ok;

    always_comb begin
        if (prescale_sel == sbit_pkg::PRESCALE_1) begin
            pre_term = sbit_pkg::TERM_1;
        end else if (prescale_sel == sbit_pkg::PRESCALE_8) begin
            pre_term = sbit_pkg::TERM_8;
        end else if (prescale_sel == sbit_pkg::PRESCALE_64) begin
            pre_term = sbit_pkg::TERM_64;
        end else begin
            pre_term = sbit_pkg::TERM_256;
        end
    end

    assign pre_out = pre_in && (pre_cnt_q >= pre_term); // RL10

    // The prescaler restarts whenever the run bit is clear or the count or control register is written.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_cnt_q <= 8'h00;
        end else if (!count_run || cnt_wr || ctrl_wr) begin
            pre_cnt_q <= 8'h00;
        end else if (pre_out) begin
            pre_cnt_q <= 8'h00;
        end else if (pre_in) begin
            pre_cnt_q <= pre_cnt_q + 8'h01; // RL10
        end
    end

    // Synchronised counter mode retimes the prescaled tick by two stages.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            resync_q <= 2'h0;
        end else if (!active) begin
            resync_q <= 2'h0;
        end else begin
            resync_q <= {resync_q[0], pre_out}; // RL4
        end
    end

    // Asynchronous mode takes the prescaled tick straight, saving two cycles.
    assign cnt_tick = (count_source_sel && ext_input_sync) ? (resync_q[1] && active) : pre_out; // RL4 RL5 RL12

    // ------------------------------------------------------------------
    // Counter, period match and interrupt
    // ------------------------------------------------------------------
    logic period_hit;

    assign period_hit = cnt_tick && (count_value_q == period_q);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_value_q <= sbit_pkg::COUNT_RESET;
        end else if (cnt_wr && !sync_counter) begin
            count_value_q <= pwdata[15:0]; // RL13
        end else if (period_hit) begin
            count_value_q <= 16'h0000; // RL14
        end else if (cnt_tick) begin
            count_value_q <= count_value_q + 16'h0001; // RL1
        end
    end

    // A match in the clearing cycle keeps the flag set.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= sbit_pkg::STATUS_RESET;
        end else begin
            status_q <= (status_q && !(stat_wr && pwdata[0])) || period_hit; // RL14
        end
    end

    assign irq = status_q && mask_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_run_stops_count: assert property (@(posedge core_clk) disable iff (!rst_n) // RL6
        (!count_run && !cnt_wr) |=> (count_value_q == $past(count_value_q)))
        else $error("count moved while stopped");

    a_idle_halts_count: assert property (@(posedge core_clk) disable iff (!rst_n) // RL7
        (count_run && halt_in_idle && idle_mode && !cnt_wr) |=> (count_value_q == $past(count_value_q)))
        else $error("count moved in idle with halt set");

    a_gate_low_holds: assert property (@(posedge core_clk) disable iff (!rst_n) // RL8
        (!count_source_sel && gate_accumulate_en && !gate_level && !cnt_wr) |=>
        (count_value_q == $past(count_value_q)))
        else $error("gated timer counted with gate low");

    a_gate_ignored_ext: assert property (@(posedge core_clk) disable iff (!rst_n) // RL9
        (count_source_sel && active && ext_rise) |-> pre_in)
        else $error("gate blocked an external edge");

    a_timer_each_cycle: assert property (@(posedge core_clk) disable iff (!rst_n) // RL2
        (active && !count_source_sel && !gate_accumulate_en && prescale_sel == 2'h0 && !cnt_wr
        && !ctrl_wr && count_value_q != period_q) |=> (count_value_q == $past(count_value_q) + 16'h0001))
        else $error("timer did not count every cycle at 1:1");

    a_prescale_eight: assert property (@(posedge core_clk) disable iff (!rst_n) // RL10
        (pre_out && prescale_sel == 2'h1 && !count_source_sel && !gate_accumulate_en && !halt_in_idle) |->
        ($past(pre_in, 7) && $past(count_run, 7)))
        else $error("1:8 prescaler fired early");

    a_sync_after_pre: assert property (@(posedge core_clk) disable iff (!rst_n) // RL12
        (cnt_tick && count_source_sel && ext_input_sync) |-> $past(pre_out, 2))
        else $error("synchronised tick without prescaler output");

    a_async_direct: assert property (@(posedge core_clk) disable iff (!rst_n) // RL5
        (count_source_sel && !ext_input_sync) |-> (cnt_tick == pre_out))
        else $error("asynchronous tick was delayed");

    a_pin_edge_counts: assert property (@(posedge core_clk) disable iff (!rst_n) // RL11
        (active && count_source_sel && !ext_input_sync && prescale_sel == 2'h0 && ext_rise
        && !cnt_wr && !ctrl_wr && count_value_q != period_q) |=>
        (count_value_q == $past(count_value_q) + 16'h0001))
        else $error("pin edge not counted");

    a_write_ignored: assert property (@(posedge core_clk) disable iff (!rst_n) // RL13
        (cnt_wr && sync_counter && !cnt_tick) |=> (count_value_q == $past(count_value_q)))
        else $error("count write taken in synchronous counter");

    a_period_wrap: assert property (@(posedge core_clk) disable iff (!rst_n) // RL14
        (cnt_tick && count_value_q == period_q && !(cnt_wr && !sync_counter)) |=>
        (count_value_q == 16'h0000 && status_q))
        else $error("period match did not wrap and flag");

endmodule : sbit_timer

/* File: sbit_pulse_src.sv */
/*
 * Model of the external clock source that drives the count input pin.
 * Assumes go is a one-cycle request on core_clk and n_pulses is not zero.
 */
`timescale 1ns/10ps

module sbit_pulse_src (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [7:0] n_pulses,
    output logic ext_count_pin,
    output logic busy
);
    // ------------------------------------------------------------------
    // Pulse train
    // ------------------------------------------------------------------
    // Three cycles high and three low keeps every level longer than the
    // pin synchroniser needs; the pin rests low between trains.
    logic [7:0] left_q = 8'h00;
    logic [2:0] ph_q = 3'h0;

    initial begin
        ext_count_pin = 1'b0;
        busy = 1'b0;
    end

    always @(posedge core_clk) begin
        if (go) begin
            left_q <= n_pulses;
            ph_q <= 3'h0;
            busy <= 1'b1;
        end else if (busy) begin
            ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
            ext_count_pin <= (ph_q < 3'h3);
            if (ph_q == 3'h5) begin
                left_q <= left_q - 8'h01;
                busy <= (left_q != 8'h01);
            end
        end
    end
endmodule : sbit_pulse_src

/* File: sixteen_bit_interval_timer_tb.sv */
/*
 * Self-checking bench of the interval timer: APB register access, count
 * sources, prescaler, gate, idle halt, period match and interrupt.
 * Assumes zero-wait APB answers and the pulse source model beside it.
 */
`timescale 1ns/10ps

module sixteen_bit_interval_timer_tb;
    logic core_clk, reset_n, psel, penable, pwrite, gate_in, idle_mode, go;
    logic pready, pslverr, irq, ext_count_pin, busy, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] n_pulses;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc = 0;
    int ns[4] = '{1, 8, 64, 256};

    sbit_timer uut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_pin(ext_count_pin), .gate_in(gate_in),
        .idle_mode(idle_mode), .irq(irq));
    sbit_pulse_src src (.core_clk(core_clk), .go(go), .n_pulses(n_pulses),
        .ext_count_pin(ext_count_pin), .busy(busy));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // The ceiling is about ten times the length of the planned tests.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_mismatch++;
            summarize();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int t;
        t = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1 && t < 20) begin
            @(posedge core_clk);
            t++;
        end
        if (t == 20) begin
            n_mismatch++;
            $display("[FAIL] pready expected 1 seen %b", pready);
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdc(input logic [11:0] ad, input logic [31:0] exp, input string what);
        apb(1'b0, ad, 32'h0);
        check(what, exp, rd);
    endtask : rdc

    task automatic cfg(input logic [31:0] c);
        apb(1'b1, sbit_pkg::OFS_CONTROL, 32'h0);
        apb(1'b1, sbit_pkg::OFS_COUNT, 32'h0);
        apb(1'b1, sbit_pkg::OFS_CONTROL, c);
    endtask : cfg

    // Two count reads whose setup edges lie k cycles apart.
    task automatic gap(input int k, input logic [31:0] exp, input string what);
        logic [31:0] a;
        apb(1'b0, sbit_pkg::OFS_COUNT, 32'h0);
        a = rd;
        repeat (k - 3) @(posedge core_clk);
        apb(1'b0, sbit_pkg::OFS_COUNT, 32'h0);
        check(what, exp, rd - a);
    endtask : gap

    task automatic ext(input logic [7:0] n, input logic [31:0] exp, input string what);
        logic [31:0] a;
        apb(1'b0, sbit_pkg::OFS_COUNT, 32'h0);
        a = rd;
        @(posedge core_clk);
        n_pulses <= n;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        // The model raises busy at the edge that samples go, so look one edge later.
        @(posedge core_clk);
        while (busy === 1'b1) @(posedge core_clk);
        repeat (8) @(posedge core_clk);
        apb(1'b0, sbit_pkg::OFS_COUNT, 32'h0);
        check(what, exp, rd - a);
    endtask : ext

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        gate_in = 1'b0;
        idle_mode = 1'b0;
        go = 1'b0;
        n_pulses = 8'h00;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdc(sbit_pkg::OFS_CONTROL, 32'h0, "control reset");
        rdc(sbit_pkg::OFS_COUNT, 32'h0, "count reset");
        rdc(sbit_pkg::OFS_PERIOD, 32'hffff, "period reset");
        rdc(sbit_pkg::OFS_STATUS, 32'h0, "status reset");
        rdc(sbit_pkg::OFS_MASK, 32'h0, "mask reset");
        apb(1'b0, 12'h014, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, sbit_pkg::OFS_CONTROL, 32'hffff);
        rdc(sbit_pkg::OFS_CONTROL, 32'ha076, "control bits");
        $display("test registers done");
        for (int p = 0; p < 4; p++) begin
            cfg(32'h8000 | (p << 4));
            gap(8 * ns[p], 8, "prescaled count");
        end
        apb(1'b1, sbit_pkg::OFS_CONTROL, 32'h0);
        gap(20, 0, "stopped count");
        $display("test prescaler done");
        cfg(32'ha000);
        idle_mode <= 1'b1;
        gap(8, 0, "idle halted count");
        idle_mode <= 1'b0;
        gap(8, 8, "idle released count");
        cfg(32'h8000);
        idle_mode <= 1'b1;
        gap(8, 8, "idle kept count");
        idle_mode <= 1'b0;
        $display("test idle done");
        cfg(32'h8040);
        repeat (5) @(posedge core_clk);
        gap(8, 0, "gate low count");
        gate_in <= 1'b1;
        repeat (5) @(posedge core_clk);
        gap(8, 8, "gate high count");
        gate_in <= 1'b0;
        $display("test gate done");
        cfg(32'h8046);
        ext(8'h05, 5, "sync pin count");
        gap(16, 0, "pin idle count");
        cfg(32'h8016);
        ext(8'h10, 2, "sync prescaled pin count");
        cfg(32'h8002);
        ext(8'h06, 6, "async pin count");
        cfg(32'h8006);
        apb(1'b1, sbit_pkg::OFS_COUNT, 32'h1234);
        rdc(sbit_pkg::OFS_COUNT, 32'h0, "sync count write");
        cfg(32'h8002);
        apb(1'b1, sbit_pkg::OFS_COUNT, 32'h1234);
        rdc(sbit_pkg::OFS_COUNT, 32'h1234, "async count write");
        $display("test external done");
        cfg(32'h0);
        apb(1'b1, sbit_pkg::OFS_PERIOD, 32'h5);
        apb(1'b1, sbit_pkg::OFS_MASK, 32'h1);
        apb(1'b1, sbit_pkg::OFS_CONTROL, 32'h8000);
        repeat (20) @(posedge core_clk);
        check("irq on match", 32'h1, {31'h0, irq});
        rdc(sbit_pkg::OFS_STATUS, 32'h1, "match status");
        apb(1'b1, sbit_pkg::OFS_CONTROL, 32'h0);
        apb(1'b0, sbit_pkg::OFS_COUNT, 32'h0);
        check("count within period", 32'h1, {31'h0, rd <= 32'h5});
        apb(1'b1, sbit_pkg::OFS_MASK, 32'h0);
        repeat (2) @(posedge core_clk);
        check("masked irq", 32'h0, {31'h0, irq});
        apb(1'b1, sbit_pkg::OFS_STATUS, 32'h1);
        rdc(sbit_pkg::OFS_STATUS, 32'h0, "cleared status");
        apb(1'b1, sbit_pkg::OFS_MASK, 32'h1);
        repeat (2) @(posedge core_clk);
        check("irq after clear", 32'h0, {31'h0, irq});
        $display("test period done");
        summarize();
    end
endmodule : sixteen_bit_interval_timer_tb
